// ===== rtl/rsc_defs.svh
// offsets, field positions, reset values and timing counts of the reset source controller
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

`define RSC_CLK_MHZ          10
`define RSC_SW_HOLD_NS       1000
`define RSC_SW_HOLD_CYC      ((`RSC_SW_HOLD_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_HOLD_W           8

`define RSC_NUM_PERIPH       8
`define RSC_NUM_CAUSE        5
`define RSC_NUM_IRQ          2
`define RSC_NUM_PIN          3

`define RSC_OFF_CAUSE        8'h00
`define RSC_OFF_CORE_CTRL    8'h04
`define RSC_OFF_SOFT_RST     8'h08
`define RSC_OFF_SUPPLY       8'h0c
`define RSC_OFF_IRQ_STAT     8'h10
`define RSC_OFF_IRQ_MASK     8'h14
`define RSC_OFF_IDENT0       8'h18
`define RSC_OFF_IDENT1       8'h1c
`define RSC_OFF_PIN_STAT     8'h20
`define RSC_OFF_UNMAPPED     8'hff

`define RSC_CAUSE_EXT        0
`define RSC_CAUSE_POR        1
`define RSC_CAUSE_DROOP      2
`define RSC_CAUSE_SW         3
`define RSC_CAUSE_WDOG       4
`define RSC_CAUSE_RST        5'h02
`define RSC_CAUSE_EXT_ONLY   5'h01

`define RSC_CORE_SYSREQ      2
`define RSC_SUP_DROOP_EN     1
`define RSC_SUP_RST          1'h0
`define RSC_SOFT_RST         8'h00

`define RSC_IRQ_DROOP        0
`define RSC_IRQ_TMODE        1
`define RSC_IRQ_RST          2'h0

`define RSC_PIN_DROOP        0
`define RSC_PIN_TM0          1
`define RSC_PIN_TM1          2

`endif

// ===== rtl/rsc_pkg.sv
// types shared by the reset source controller
package rsc_pkg;
    typedef logic [4:0] rsc_cause_type;
    typedef logic [7:0] rsc_periph_type;
    typedef logic [1:0] rsc_irq_type;
    typedef enum logic [1:0] {RSC_PH_IDLE, RSC_PH_WRITE, RSC_PH_READ_WAIT, RSC_PH_READ_DONE}
        rsc_phase_type;
endpackage

// ===== rtl/rsc_reset_controller.sv
// reset source controller: reset domains, cause flags and ahb-lite register file
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_reset_controller
#(
    parameter logic [31:0] IDENT0 = 32'h0001_0000,  // arbitrary value
    parameter logic [31:0] IDENT1 = 32'h0000_0001   // arbitrary value
)
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    input  wire logic        ext_rst_n_i,
    input  wire logic        droop_det_i,
    input  wire logic        wdog_rst_req_i,
    input  wire logic        test_mode_sel0_i,
    input  wire logic        test_mode_sel1_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic             core_rst_o,
    output logic             tap_rst_o,
    output logic             tap_pin_cfg_rst_o,
    output logic      [7:0]  periph_rst_o,
    output logic             irq_o
);
    // address decode shared by read and write paths
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction

    // ---------------------------------------------------------------- pin reset path
    logic ext_arst;
    logic ext_hold;

    assign ext_arst = rst_i | ~ext_rst_n_i;

    rsc_rst_sync u_ext_sync
    (
        .clk_i  (ref_clk_i),
        .ce_i   (clk_en_i),
        .arst_i (ext_arst),
        .rst_o  (ext_hold)
    );

    // ---------------------------------------------------------------- pin filters
    logic [2:0] pin_raw;
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic [2:0] pin_s3_r;
    logic [2:0] pin_flt_r;

    assign pin_raw = {test_mode_sel1_i, test_mode_sel0_i, droop_det_i};

    genvar g;
    generate
        for (g = 0; g < `RSC_NUM_PIN; g++)
        begin : g_pin
            always_ff @(posedge ref_clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    pin_s1_r[g]  <= 1'b0;
                    pin_s2_r[g]  <= 1'b0;
                    pin_s3_r[g]  <= 1'b0;
                    pin_flt_r[g] <= 1'b0;
                end
                else if (clk_en_i)
                begin
                    pin_s1_r[g] <= pin_raw[g];
                    pin_s2_r[g] <= pin_s1_r[g];
                    pin_s3_r[g] <= pin_s2_r[g];
                    if (pin_s2_r[g] == pin_s3_r[g])
                    begin
                        pin_flt_r[g] <= pin_s3_r[g];
                    end
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------- bus slave
    rsc_pkg::rsc_phase_type phase_r;
    rsc_pkg::rsc_phase_type phase_nxt;
    rsc_pkg::rsc_phase_type phase_base;
    logic [7:0]             addr_r;
    logic [7:0]             addr_nxt;
    logic                   addr_take;
    logic                   wr_en;
    logic [31:0]            rd_data;

    assign addr_take  = hsel_i & htrans_i[1] & hready_i;
    assign addr_nxt   = (haddr_i[31:8] == 24'h0) ? {haddr_i[7:2], 2'b00} : `RSC_OFF_UNMAPPED;
    assign phase_base = !addr_take ? rsc_pkg::RSC_PH_IDLE :
                        hwrite_i   ? rsc_pkg::RSC_PH_WRITE : rsc_pkg::RSC_PH_READ_WAIT;
    assign wr_en      = (phase_r == rsc_pkg::RSC_PH_WRITE);

    always_comb
    begin
        unique case (phase_r)
            rsc_pkg::RSC_PH_IDLE:      phase_nxt = phase_base;
            rsc_pkg::RSC_PH_WRITE:     phase_nxt = phase_base;
            rsc_pkg::RSC_PH_READ_WAIT: phase_nxt = rsc_pkg::RSC_PH_READ_DONE;
            rsc_pkg::RSC_PH_READ_DONE: phase_nxt = phase_base;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            phase_r     <= rsc_pkg::RSC_PH_IDLE;
            addr_r      <= 8'h00;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            hrdata_o    <= 32'h0000_0000;
        end
        else if (clk_en_i)
        begin
            phase_r     <= phase_nxt;
            hreadyout_o <= (phase_nxt != rsc_pkg::RSC_PH_READ_WAIT);
            hresp_o     <= 1'b0;
            if (addr_take)
            begin
                addr_r <= addr_nxt;
            end
            if (phase_r == rsc_pkg::RSC_PH_READ_WAIT)
            begin
                hrdata_o <= rd_data;
            end
        end
    end

    // ---------------------------------------------------------------- write strobes
    logic wr_cause;
    logic wr_core;
    logic wr_soft;
    logic wr_supply;
    logic wr_irq_stat;
    logic wr_irq_mask;

    assign wr_cause    = wr_en & reg_hit(addr_r, `RSC_OFF_CAUSE);
    assign wr_core     = wr_en & reg_hit(addr_r, `RSC_OFF_CORE_CTRL);
    assign wr_soft     = wr_en & reg_hit(addr_r, `RSC_OFF_SOFT_RST);
    assign wr_supply   = wr_en & reg_hit(addr_r, `RSC_OFF_SUPPLY);
    assign wr_irq_stat = wr_en & reg_hit(addr_r, `RSC_OFF_IRQ_STAT);
    assign wr_irq_mask = wr_en & reg_hit(addr_r, `RSC_OFF_IRQ_MASK);

    // ---------------------------------------------------------------- reset sources
    logic                  droop_en_r;
    logic                  droop_rst;
    logic                  droop_rst_q_r;
    logic                  droop_flt_q_r;
    logic                  sys_req;
    logic                  tmode_bad;
    logic                  tmode_bad_q_r;
    logic [`RSC_HOLD_W-1:0] hold_cnt_r;
    logic                  hold_busy;
    logic                  core_level;
    logic                  ext_seen_r;
    logic                  ext_evt;

    assign droop_rst  = pin_flt_r[`RSC_PIN_DROOP] & droop_en_r;
    assign sys_req    = wr_core & hwdata_i[`RSC_CORE_SYSREQ];
    assign tmode_bad  = pin_flt_r[`RSC_PIN_TM0] | pin_flt_r[`RSC_PIN_TM1];
    assign hold_busy  = (hold_cnt_r != '0);
    assign core_level = ext_hold | droop_rst | hold_busy;
    assign ext_evt    = ext_hold & ~ext_seen_r;

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            droop_en_r    <= `RSC_SUP_RST;
            droop_rst_q_r <= 1'b0;
            droop_flt_q_r <= 1'b0;
            tmode_bad_q_r <= 1'b0;
            ext_seen_r    <= 1'b1;
            hold_cnt_r    <= '0;
        end
        else if (clk_en_i)
        begin
            if (wr_supply)
            begin
                droop_en_r <= hwdata_i[`RSC_SUP_DROOP_EN];
            end
            droop_rst_q_r <= droop_rst;
            droop_flt_q_r <= pin_flt_r[`RSC_PIN_DROOP];
            tmode_bad_q_r <= tmode_bad;
            ext_seen_r    <= ext_hold;
            if (sys_req | wdog_rst_req_i)
            begin
                hold_cnt_r <= `RSC_HOLD_W'(`RSC_SW_HOLD_CYC);
            end
            else if (hold_busy)
            begin
                hold_cnt_r <= hold_cnt_r - `RSC_HOLD_W'(1);
            end
        end
    end

    // ---------------------------------------------------------------- cause flags
    rsc_pkg::rsc_cause_type cause_r;
    rsc_pkg::rsc_cause_type cause_set;
    rsc_pkg::rsc_cause_type cause_clr;
    rsc_pkg::rsc_cause_type cause_nxt;

    // power-on flag only comes from the reset value, never set later
    assign cause_set[`RSC_CAUSE_EXT]   = 1'b0;
    assign cause_set[`RSC_CAUSE_POR]   = 1'b0;
    assign cause_set[`RSC_CAUSE_DROOP] = droop_rst & ~droop_rst_q_r;
    assign cause_set[`RSC_CAUSE_SW]    = sys_req;
    assign cause_set[`RSC_CAUSE_WDOG]  = wdog_rst_req_i;
    assign cause_clr = wr_cause ? hwdata_i[`RSC_NUM_CAUSE-1:0] : '0;
    // pin reset wipes the rest, otherwise set beats clear
    assign cause_nxt = ext_evt ? `RSC_CAUSE_EXT_ONLY : ((cause_r & ~cause_clr) | cause_set);

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cause_r <= `RSC_CAUSE_RST;
        end
        else if (clk_en_i)
        begin
            cause_r <= cause_nxt;
        end
    end

    // ---------------------------------------------------------------- soft resets
    rsc_pkg::rsc_periph_type soft_r;

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            soft_r <= `RSC_SOFT_RST;
        end
        else if (clk_en_i)
        begin
            if (core_rst_o)
            begin
                soft_r <= `RSC_SOFT_RST;
            end
            else if (wr_soft)
            begin
                soft_r <= hwdata_i[`RSC_NUM_PERIPH-1:0];
            end
        end
    end

    // ---------------------------------------------------------------- interrupts
    rsc_pkg::rsc_irq_type irq_stat_r;
    rsc_pkg::rsc_irq_type irq_mask_r;
    rsc_pkg::rsc_irq_type irq_set;
    rsc_pkg::rsc_irq_type irq_clr;

    // droop with reset disabled interrupts instead
    assign irq_set[`RSC_IRQ_DROOP] = pin_flt_r[`RSC_PIN_DROOP] & ~droop_flt_q_r & ~droop_en_r;
    assign irq_set[`RSC_IRQ_TMODE] = tmode_bad & ~tmode_bad_q_r;
    assign irq_clr = wr_irq_stat ? hwdata_i[`RSC_NUM_IRQ-1:0] : '0;

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_stat_r <= `RSC_IRQ_RST;
            irq_mask_r <= `RSC_IRQ_RST;
            irq_o      <= 1'b0;
        end
        else if (clk_en_i)
        begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            if (wr_irq_mask)
            begin
                irq_mask_r <= hwdata_i[`RSC_NUM_IRQ-1:0];
            end
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ---------------------------------------------------------------- reset domain outputs
    // core and peripherals assert at once on the pin or power-on
    always_ff @(posedge ref_clk_i or posedge ext_arst)
    begin
        if (ext_arst)
        begin
            core_rst_o        <= 1'b1;
            periph_rst_o      <= 8'hff;
            tap_pin_cfg_rst_o <= 1'b1;
        end
        else if (clk_en_i)
        begin
            core_rst_o        <= core_level;
            periph_rst_o      <= {`RSC_NUM_PERIPH{core_level}} | soft_r;
            tap_pin_cfg_rst_o <= ext_hold;
        end
    end

    // test port logic only sees power-on
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tap_rst_o <= 1'b1;
        end
        else if (clk_en_i)
        begin
            tap_rst_o <= 1'b0;
        end
    end

    // ---------------------------------------------------------------- read mux
    logic [31:0] pin_word;
    logic [31:0] supply_word;

    assign pin_word    = {29'h0, tmode_bad, pin_flt_r[`RSC_PIN_TM1:`RSC_PIN_TM0]} |
                         {31'h0, 1'b0} | ({31'h0, pin_flt_r[`RSC_PIN_DROOP]} << 3);
    assign supply_word = {31'h0, droop_en_r} << `RSC_SUP_DROOP_EN;

    // identification words are read-only
    assign rd_data = reg_hit(addr_r, `RSC_OFF_CAUSE)     ? {27'h0, cause_r}    :
                     reg_hit(addr_r, `RSC_OFF_SOFT_RST)  ? {24'h0, soft_r}     :
                     reg_hit(addr_r, `RSC_OFF_SUPPLY)    ? supply_word         :
                     reg_hit(addr_r, `RSC_OFF_IRQ_STAT)  ? {30'h0, irq_stat_r} :
                     reg_hit(addr_r, `RSC_OFF_IRQ_MASK)  ? {30'h0, irq_mask_r} :
                     reg_hit(addr_r, `RSC_OFF_IDENT0)    ? IDENT0              :
                     reg_hit(addr_r, `RSC_OFF_IDENT1)    ? IDENT1              :
                     reg_hit(addr_r, `RSC_OFF_PIN_STAT)  ? pin_word            :
                     32'h0000_0000;

    // hsize is unused: every transfer is served as a whole word
    logic unused_size;
    assign unused_size = ^hsize_i;
endmodule

// ===== rtl/rsc_rst_sync.sv
// reset synchroniser: asserts at once, releases after two clock edges
`timescale 1ns/1ps
module rsc_rst_sync
(
    input  wire logic clk_i,
    input  wire logic ce_i,
    input  wire logic arst_i,
    output logic      rst_o
);
    logic meta_r;

    always_ff @(posedge clk_i or posedge arst_i)
    begin
        if (arst_i)
        begin
            meta_r <= 1'b1;
            rst_o  <= 1'b1;
        end
        else if (ce_i)
        begin
            meta_r <= 1'b0;
            rst_o  <= meta_r;
        end
    end
endmodule

// ===== verif/rsc_board_model.sv
// board reset circuitry and reset request sources
`timescale 1ns/1ps
module rsc_board_model
#(
    parameter int MIN_LOW = 4
)
(
    input  wire logic clk_i,
    output logic      ext_rst_n_o,
    output logic      droop_o,
    output logic      wdog_o,
    output logic      tm0_o,
    output logic      tm1_o
);
    initial
    begin
        ext_rst_n_o = 1'b1;
        droop_o = 1'b0;
        wdog_o = 1'b0;
        tm0_o = 1'b0;
        tm1_o = 1'b0;
    end

    // test mode selects: grounded except when a scenario probes the reserved codes
    task set_tmode(input logic [1:0] v);
        @(posedge clk_i);
        tm0_o <= v[0];
        tm1_o <= v[1];
    endtask

    task pin_reset(input int n);
        @(posedge clk_i);
        ext_rst_n_o <= 1'b0;
        repeat ((n < MIN_LOW) ? MIN_LOW : n) @(posedge clk_i);
        ext_rst_n_o <= 1'b1;
    endtask

    task wdog_pulse;
        @(posedge clk_i);
        wdog_o <= 1'b1;
        @(posedge clk_i);
        wdog_o <= 1'b0;
    endtask

    task set_droop(input logic v);
        @(posedge clk_i);
        droop_o <= v;
    endtask
endmodule

// ===== verif/rsc_reset_controller_bench.sv
// self-checking bench of the reset source controller
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_reset_controller_bench;
    localparam logic [31:0] ID0 = 32'h1234_5678; // arbitrary value
    localparam logic [31:0] ID1 = 32'h0000_00a5; // arbitrary value
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic        clk_en = 1'b1;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    wire  [31:0] hrdata;
    wire  [7:0]  periph;
    wire         hready, hresp, core_rst, tap_rst, cfg_rst, irq;
    wire         ext_n, droop, wdog, tm0, tm1;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    always #50 clk = ~clk;

    rsc_board_model i_board (.clk_i(clk), .ext_rst_n_o(ext_n), .droop_o(droop),
        .wdog_o(wdog), .tm0_o(tm0), .tm1_o(tm1));

    rsc_reset_controller #(.IDENT0(ID0), .IDENT1(ID1)) i_dut (.ref_clk_i(clk), .rst_i(rst),
        .clk_en_i(clk_en), .ext_rst_n_i(ext_n), .droop_det_i(droop), .wdog_rst_req_i(wdog),
        .test_mode_sel0_i(tm0), .test_mode_sel1_i(tm1), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .core_rst_o(core_rst), .tap_rst_o(tap_rst), .tap_pin_cfg_rst_o(cfg_rst),
        .periph_rst_o(periph), .irq_o(irq));

    task close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one single word transfer, read data left in rd
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge clk iff hready === 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk iff hready === 1'b1);
        rd = hrdata;
    endtask

    task settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task wait_rel;
        int n;
        n = 0;
        while (core_rst !== 1'b0 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        chk("core release", 32'h0, {31'h0, core_rst});
    endtask

    task t_power_on;
        chk("tap after power-on", 32'h0, {31'h0, tap_rst});
        bus(1'b0, `RSC_OFF_CAUSE, 32'h0);
        chk("cause power-on", 32'h2, rd);
        bus(1'b0, `RSC_OFF_IDENT0, 32'h0);
        chk("ident0", ID0, rd);
        bus(1'b1, `RSC_OFF_IDENT1, 32'hffff_ffff);
        bus(1'b0, `RSC_OFF_IDENT1, 32'h0);
        chk("ident1 read-only", ID1, rd);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask

    task t_watchdog;
        i_board.wdog_pulse();
        settle(3);
        chk("core in wdog", 32'h1, {31'h0, core_rst});
        chk("tap in wdog", 32'h0, {31'h0, tap_rst});
        wait_rel;
        bus(1'b0, `RSC_OFF_CAUSE, 32'h0);
        chk("cause sticky wdog", 32'h12, rd);
    endtask

    task t_sys_request;
        bus(1'b1, `RSC_OFF_CORE_CTRL, 32'h4);
        settle(3);
        chk("core in sys", 32'h1, {31'h0, core_rst});
        chk("tap in sys", 32'h0, {31'h0, tap_rst});
        wait_rel;
        bus(1'b0, `RSC_OFF_CAUSE, 32'h0);
        chk("cause sys", 32'h1a, rd);
    endtask

    task t_soft;
        bus(1'b1, `RSC_OFF_SOFT_RST, 32'h81);
        settle(2);
        chk("periph select", 32'h81, {24'h0, periph});
        chk("core kept", 32'h0, {31'h0, core_rst});
        bus(1'b1, `RSC_OFF_SOFT_RST, 32'h0);
        settle(2);
        chk("periph freed", 32'h0, {24'h0, periph});
    endtask

    task t_droop;
        i_board.set_droop(1'b1);
        settle(8);
        chk("droop disabled", 32'h0, {31'h0, core_rst});
        bus(1'b0, `RSC_OFF_IRQ_STAT, 32'h0);
        chk("droop irq flag", 32'h1, rd);
        bus(1'b1, `RSC_OFF_IRQ_MASK, 32'h1);
        settle(2);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        bus(1'b1, `RSC_OFF_IRQ_MASK, 32'h0);
        settle(2);
        chk("irq masked", 32'h0, {31'h0, irq});
        i_board.set_droop(1'b0);
        settle(6);
        bus(1'b1, `RSC_OFF_IRQ_STAT, 32'h1);
        bus(1'b1, `RSC_OFF_IRQ_MASK, 32'h1);
        settle(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        bus(1'b1, `RSC_OFF_SUPPLY, 32'h2);
        i_board.set_droop(1'b1);
        settle(8);
        chk("droop reset", 32'h1, {31'h0, core_rst});
        chk("tap in droop", 32'h0, {31'h0, tap_rst});
        i_board.set_droop(1'b0);
        wait_rel;
        bus(1'b0, `RSC_OFF_CAUSE, 32'h0);
        chk("cause droop", 32'h1e, rd);
    endtask

    task t_pin;
        bus(1'b1, `RSC_OFF_SOFT_RST, 32'h3c);
        i_board.pin_reset(6);
        wait_rel;
        chk("tap in pin", 32'h0, {31'h0, tap_rst});
        bus(1'b0, `RSC_OFF_CAUSE, 32'h0);
        chk("cause pin only", 32'h1, rd);
        bus(1'b0, `RSC_OFF_SUPPLY, 32'h0);
        chk("supply kept", 32'h2, rd);
        bus(1'b0, `RSC_OFF_SOFT_RST, 32'h0);
        chk("soft cleared", 32'h0, rd);
        bus(1'b1, `RSC_OFF_SUPPLY, 32'h0);
    endtask

    // clock enable low freezes the pin filters; reserved test mode code raises irq bit 1
    task t_test_mode;
        clk_en <= 1'b0;
        i_board.set_tmode(2'b01);
        settle(8);
        i_board.set_tmode(2'b00);
        settle(2);
        clk_en <= 1'b1;
        settle(8);
        bus(1'b0, `RSC_OFF_IRQ_STAT, 32'h0);
        chk("irq while frozen", 32'h0, rd);
        i_board.set_tmode(2'b01);
        settle(8);
        bus(1'b0, `RSC_OFF_IRQ_STAT, 32'h0);
        chk("test mode irq flag", 32'h2, rd);
        bus(1'b0, `RSC_OFF_PIN_STAT, 32'h0);
        chk("pin status", 32'h5, rd);
        bus(1'b1, `RSC_OFF_IRQ_MASK, 32'h2);
        settle(2);
        chk("test mode irq out", 32'h1, {31'h0, irq});
        i_board.set_tmode(2'b00);
        settle(6);
        bus(1'b1, `RSC_OFF_IRQ_STAT, 32'h2);
        settle(2);
        chk("test mode irq cleared", 32'h0, {31'h0, irq});
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            close_out;
        end
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wait_rel;
        t_power_on;
        t_watchdog;
        t_sys_request;
        t_soft;
        t_droop;
        t_pin;
        t_test_mode;
        close_out;
    end
endmodule

// ===== verif/rsc_reset_controller_sva.sv
// port checker for the reset source controller
`timescale 1ns/1ps
module rsc_reset_controller_sva
(
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic       ext_rst_n_i,
    input wire logic       wdog_rst_req_i,
    input wire logic       hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic       hwrite_i,
    input wire logic       hready_i,
    input wire logic       hreadyout_o,
    input wire logic       core_rst_o,
    input wire logic       tap_rst_o,
    input wire logic       tap_pin_cfg_rst_o,
    input wire logic [7:0] periph_rst_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire bus_take = hsel_i && htrans_i[1] && hready_i;

    a_por_release: assert property ($fell(rst_i) |-> tap_rst_o && core_rst_o
        ##1 !tap_rst_o && core_rst_o ##1 core_rst_o
        ##1 !core_rst_o && periph_rst_o == 8'h00)
        else $error("power-on release sequence wrong");
    a_tap_stays_off: assert property (!tap_rst_o |=> !tap_rst_o)
        else $error("test port logic reset outside power-on");
    a_pin_async_hold: assert property (!ext_rst_n_i |-> core_rst_o && tap_pin_cfg_rst_o
        && periph_rst_o == 8'hff)
        else $error("pin low without core and peripheral reset");
    a_pin_sync_release: assert property ($rose(ext_rst_n_i) |-> core_rst_o[*3]
        ##1 !core_rst_o)
        else $error("pin release not three edges late");
    a_wdog_hold: assert property (wdog_rst_req_i |-> ##2 core_rst_o[*8]
        ##[1:6] !core_rst_o)
        else $error("watchdog reset hold wrong");
    a_core_with_periph: assert property (core_rst_o |-> periph_rst_o == 8'hff)
        else $error("core reset without all peripherals");
    a_cfg_with_core: assert property (tap_pin_cfg_rst_o |-> core_rst_o)
        else $error("pin config reset without core reset");
    a_read_one_wait: assert property (bus_take && !hwrite_i |=> !hreadyout_o
        ##1 hreadyout_o)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (bus_take && hwrite_i |=> hreadyout_o)
        else $error("write stalled");

    c_wdog: cover property (wdog_rst_req_i ##2 core_rst_o);
    c_pin: cover property ($fell(ext_rst_n_i));
    c_read: cover property (bus_take && !hwrite_i ##2 hreadyout_o);
endmodule

bind rsc_reset_controller rsc_reset_controller_sva i_sva (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .ext_rst_n_i(ext_rst_n_i), .wdog_rst_req_i(wdog_rst_req_i),
    .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hreadyout_o(hreadyout_o), .core_rst_o(core_rst_o), .tap_rst_o(tap_rst_o),
    .tap_pin_cfg_rst_o(tap_pin_cfg_rst_o), .periph_rst_o(periph_rst_o));
